// >>> src/barc_control_unit.sv
// Burst mode and auto-restart sequencing for an off-line switching controller
`timescale 1ns/1ps
`include "barc_map.svh"

module barc_control_unit (
    input wire logic core_clk,
    input wire logic rst,
    input wire barc_pkg::barc_sense_s sense,
    output barc_pkg::barc_drive_s drive
);
    barc_pkg::barc_state_s state;
    barc_pkg::barc_state_s next_state;
    logic tick;
    logic faultNow;
    logic extRequest;
    logic gateInputs;
    logic ovpFault;

    // One time-base tick per divider wrap
    assign tick = (state.tickDiv == 5'(`BARC_TICK_DIV - 1));
    // External request blanked while early in startup
    assign extRequest = sense.pinBelowExt && (state.extCnt >= 13'(`BARC_EXT_BLANK_TICKS));
    assign gateInputs = state.clampReleased && sense.pinAboveRelease;
    // Long overvoltage filter reached
    assign ovpFault = (state.ovpCnt >= 8'(`BARC_OVP_TICKS));
    // Restart faults; the pin fault only after extended blanking and spike filter
    assign faultNow = ovpFault || sense.overTemp || extRequest || sense.supplyBelowOff
        || (state.mode == barc_pkg::ST_SOFT_START && sense.supplyAboveSoftOvp && sense.fbAboveHigh)
        || (state.spikeCnt >= 8'(`BARC_SPIKE_TICKS));

    always_comb
    begin
        next_state = state;
        next_state.tickDiv = tick ? 5'h00 : state.tickDiv + 5'h01;

        // External blank counter restarts with each power-up
        if (state.mode == barc_pkg::ST_OFF || state.mode == barc_pkg::ST_RESTART)
        begin
            next_state.extCnt = 13'h0000;
        end
        else if (tick && state.extCnt < 13'(`BARC_EXT_BLANK_TICKS))
        begin
            next_state.extCnt = state.extCnt + 13'h0001;
        end

        // Overvoltage filter, must be continuous, off in burst
        if (!sense.supplyAboveOvp || state.mode == barc_pkg::ST_BURST || state.mode == barc_pkg::ST_RESTART)
        begin
            next_state.ovpCnt = 8'h00;
        end
        else if (tick && !ovpFault)
        begin
            next_state.ovpCnt = state.ovpCnt + 8'h01;
        end

        // Protection blanking on high feedback; burst never uses the pin
        if (!sense.fbAboveHigh || state.mode != barc_pkg::ST_NORMAL)
        begin
            next_state.protCnt = 17'h0_0000;
            next_state.clampReleased = 1'b0;
        end
        else if (tick && state.protCnt < 17'(`BARC_BLANK_TICKS))
        begin
            next_state.protCnt = state.protCnt + 17'h0_0001;
        end
        else if (state.protCnt >= 17'(`BARC_BLANK_TICKS))
        begin
            next_state.clampReleased = 1'b1;
        end

        // Both gate inputs must persist through the spike filter
        if (!gateInputs)
        begin
            next_state.spikeCnt = 8'h00;
        end
        else if (tick && state.spikeCnt < 8'(`BARC_SPIKE_TICKS))
        begin
            next_state.spikeCnt = state.spikeCnt + 8'h01;
        end

        // Burst entry blanking
        if (!sense.fbBelowEntry || state.mode != barc_pkg::ST_NORMAL)
        begin
            next_state.entryCnt = 17'h0_0000;
        end
        else if (tick && state.entryCnt < 17'(`BARC_BLANK_TICKS))
        begin
            next_state.entryCnt = state.entryCnt + 17'h0_0001;
        end

        unique case (state.mode)
            barc_pkg::ST_OFF:
            begin
                next_state.biasOn = 1'b0;
                next_state.softCnt = 17'h0_0000;
                if (sense.supplyAboveOn)
                begin
                    next_state.mode = barc_pkg::ST_SOFT_START;
                    next_state.biasOn = 1'b1;
                end
            end
            barc_pkg::ST_SOFT_START:
            begin
                if (faultNow)
                begin
                    next_state.mode = barc_pkg::ST_RESTART;
                end
                else if (state.softCnt >= 17'(`BARC_SOFT_START_TICKS))
                begin
                    // Fault checked each cycle, so none remains here
                    next_state.mode = barc_pkg::ST_NORMAL;
                end
                else if (tick)
                begin
                    next_state.softCnt = state.softCnt + 17'h0_0001;
                end
            end
            barc_pkg::ST_NORMAL:
            begin
                if (faultNow)
                begin
                    next_state.mode = barc_pkg::ST_RESTART;
                end
                else if (sense.fbBelowEntry && state.entryCnt >= 17'(`BARC_BLANK_TICKS))
                begin
                    next_state.mode = barc_pkg::ST_BURST;
                    next_state.biasOn = 1'b0;
                end
            end
            barc_pkg::ST_BURST:
            begin
                if (faultNow)
                begin
                    next_state.mode = barc_pkg::ST_RESTART;
                end
                else if (sense.fbAboveHigh)
                begin
                    next_state.mode = barc_pkg::ST_NORMAL;
                    next_state.biasOn = 1'b1;
                end
                else if (sense.fbAboveUpper)
                begin
                    next_state.biasOn = 1'b1;
                end
                else if (!sense.fbAboveLower)
                begin
                    next_state.biasOn = 1'b0;
                end
            end
            barc_pkg::ST_RESTART:
            begin
                // Switching stopped; supply falls toward turn-off
                next_state.biasOn = 1'b0;
                if (sense.supplyBelowOff)
                begin
                    next_state.mode = barc_pkg::ST_OFF;
                end
            end
        endcase

        next_state.drive.internalBias = next_state.biasOn;
        next_state.drive.burstFlag = (next_state.mode == barc_pkg::ST_BURST);
        next_state.drive.reducedLimit = (next_state.mode == barc_pkg::ST_BURST);
        // Cell charges only while powered down, never in burst
        next_state.drive.startupCell = (next_state.mode == barc_pkg::ST_OFF) && !sense.supplyAboveOn;
        next_state.drive.gateEnable = next_state.biasOn
            && (next_state.mode == barc_pkg::ST_SOFT_START || next_state.mode == barc_pkg::ST_NORMAL
                || next_state.mode == barc_pkg::ST_BURST);
        next_state.drive.pinClamp = !next_state.clampReleased;
        next_state.drive.softStart = (next_state.mode == barc_pkg::ST_SOFT_START);
        next_state.drive.restartActive = (next_state.mode == barc_pkg::ST_RESTART);
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state <= '{mode: barc_pkg::ST_OFF, drive: '{pinClamp: 1'b1, startupCell: 1'b1, default: 1'b0},
                default: '0};
        end
        else
        begin
            state <= next_state;
        end
    end

    assign drive = state.drive;
endmodule

// >>> src/barc_map.svh
// Timing constants of the burst and auto-restart control unit
`ifndef BARC_MAP_SVH
`define BARC_MAP_SVH
`define BARC_CLK_HZ 20000000
// Internal reference time base tick, in clock cycles
`define BARC_TICK_DIV 20
`define BARC_TICK_HZ (`BARC_CLK_HZ / `BARC_TICK_DIV)
`define BARC_BLANK_US 20000
`define BARC_BLANK_TICKS ((`BARC_BLANK_US * (`BARC_TICK_HZ / 1000)) / 1000)
`define BARC_SPIKE_US 30
`define BARC_SPIKE_TICKS ((`BARC_SPIKE_US * (`BARC_TICK_HZ / 1000) + 999) / 1000)
`define BARC_OVP_US 120
`define BARC_OVP_TICKS ((`BARC_OVP_US * (`BARC_TICK_HZ / 1000) + 999) / 1000)
`define BARC_EXT_BLANK_US 1000
`define BARC_EXT_BLANK_TICKS ((`BARC_EXT_BLANK_US * (`BARC_TICK_HZ / 1000) + 999) / 1000)
`define BARC_SOFT_START_US 20000
`define BARC_SOFT_START_TICKS ((`BARC_SOFT_START_US * (`BARC_TICK_HZ / 1000)) / 1000)
`endif

// >>> src/barc_pkg.sv
// Types of the burst and auto-restart control unit
package barc_pkg;
    typedef enum logic [2:0] {
        ST_OFF,
        ST_SOFT_START,
        ST_NORMAL,
        ST_BURST,
        ST_RESTART
    } barc_mode_e;

    // Comparator results, all synchronous to core_clk
    typedef struct packed {
        logic fbBelowEntry;
        logic fbAboveUpper;
        logic fbAboveLower;
        logic fbAboveHigh;
        logic pinAboveRelease;
        logic pinBelowExt;
        logic supplyAboveSoftOvp;
        logic supplyAboveOvp;
        logic supplyBelowOff;
        logic supplyAboveOn;
        logic overTemp;
    } barc_sense_s;

    typedef struct packed {
        logic internalBias;
        logic reducedLimit;
        logic startupCell;
        logic gateEnable;
        logic pinClamp;
        logic burstFlag;
        logic softStart;
        logic restartActive;
    } barc_drive_s;

    typedef struct packed {
        barc_mode_e mode;
        logic [4:0] tickDiv;
        logic [16:0] entryCnt;
        logic [16:0] protCnt;
        logic [16:0] softCnt;
        logic [12:0] extCnt;
        logic [7:0] spikeCnt;
        logic [7:0] ovpCnt;
        logic biasOn;
        logic clampReleased;
        barc_drive_s drive;
    } barc_state_s;
endpackage

// >>> testbench/barc_control_unit_asserts.sv
// Port checker for the burst and auto-restart control unit
`timescale 1ns/1ps
module barc_checker (
    input wire logic core_clk,
    input wire logic rst,
    input wire barc_pkg::barc_sense_s sense,
    input wire barc_pkg::barc_drive_s drive
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // Reset itself is the cause here, so this one is never disabled
    reset_state_a: assert property (disable iff (1'b0)
        rst |=> drive.pinClamp && drive.startupCell && !drive.gateEnable && !drive.burstFlag)
        else $error("reset state wrong");
    burst_cell_a: assert property (drive.burstFlag |-> !drive.startupCell)
        else $error("startup cell on in burst");
    burst_limit_a: assert property (drive.burstFlag |-> drive.reducedLimit)
        else $error("reduced limit missing in burst");
    burst_exit_a: assert property (
        drive.burstFlag && sense.fbAboveHigh |=> !drive.burstFlag && !drive.reducedLimit)
        else $error("burst not left on high feedback");
    restart_gate_a: assert property (drive.restartActive |-> !drive.gateEnable)
        else $error("switching during restart");
    cell_charge_a: assert property (
        drive.restartActive && sense.supplyBelowOff |=> drive.startupCell)
        else $error("startup cell not enabled at turn-off");
    soft_start_a: assert property ($rose(drive.softStart) |-> drive.gateEnable && !drive.startupCell)
        else $error("soft start entered badly");
    thermal_trip_a: assert property (
        drive.gateEnable && sense.overTemp |-> ##[1:2] drive.restartActive)
        else $error("no restart on overtemperature");
    soft_ovp_a: assert property (
        drive.softStart && sense.supplyAboveSoftOvp && sense.fbAboveHigh |-> ##[1:2] drive.restartActive)
        else $error("no restart on soft-start overvoltage");
    cover property ($rose(drive.restartActive));
    cover property ($rose(drive.softStart));
    cover property (drive.restartActive && sense.supplyBelowOff);
endmodule

bind barc_control_unit barc_checker u_chk (.core_clk(core_clk), .rst(rst), .sense(sense), .drive(drive));

// >>> testbench/barc_partner.sv
// Feedback network and blanking-pin model facing the control unit
`timescale 1ns/1ps
module barc_partner #(
    parameter int CHARGE_CYC = 200
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [12:0] fbMv,
    input wire logic extReq,
    input wire logic [4:0] supply,
    input wire logic pinClamp,
    output barc_pkg::barc_sense_s sense
);
    logic [15:0] chargeCnt;
    // Capacitor charges only once the clamp switch opens
    always_ff @(posedge core_clk)
    begin
        if (rst || pinClamp)
            chargeCnt <= 16'h0000;
        else if (chargeCnt < 16'(CHARGE_CYC))
            chargeCnt <= chargeCnt + 16'h0001;
    end
    // Comparators modelled as clean synchronous levels
    always_comb
    begin
        sense.fbBelowEntry = fbMv < 13'h04c4;
        sense.fbAboveUpper = fbMv > 13'h0e10;
        sense.fbAboveLower = fbMv > 13'h0c1c;
        sense.fbAboveHigh = fbMv > 13'h1194;
        sense.pinAboveRelease = !extReq && (chargeCnt == 16'(CHARGE_CYC));
        sense.pinBelowExt = extReq;
        {sense.supplyAboveSoftOvp, sense.supplyAboveOvp, sense.supplyBelowOff, sense.supplyAboveOn,
            sense.overTemp} = supply;
    end
endmodule

// >>> testbench/testbench.sv
// Self-checking bench of the burst and auto-restart control unit
`timescale 1ns/1ps
module testbench;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [12:0] fbMv = 13'h09c4;
    logic extReq = 1'b0;
    // {softOvp, ovp, belowOff, aboveOn, overTemp}
    logic [4:0] supply = 5'h00;
    barc_pkg::barc_sense_s sense;
    barc_pkg::barc_drive_s drive;
    int err_count = 0;
    int check_count = 0;
    always #25 core_clk = ~core_clk;
    barc_partner partner (.core_clk(core_clk), .rst(rst), .fbMv(fbMv), .extReq(extReq), .supply(supply),
        .pinClamp(drive.pinClamp), .sense(sense));
    barc_control_unit uut (.core_clk(core_clk), .rst(rst), .sense(sense), .drive(drive));
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks=%0d errors=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic no_restart();
        chk({7'h00, drive.restartActive}, 8'h00);
    endtask
    task automatic wait_restart(input int bound);
        for (int i = 0; i < bound && drive.restartActive !== 1'b1; i++)
            step(1);
        chk({7'h00, drive.restartActive}, 8'h01);
        if (drive.restartActive !== 1'b1)
            final_report();
    endtask
    task automatic power_on();
        supply = 5'h02;
        step(1);
        chk({4'h0, drive.softStart, drive.gateEnable, drive.internalBias, drive.startupCell}, 8'h0e);
    endtask
    task automatic power_off();
        supply = 5'h04;
        step(1);
        chk({7'h00, drive.startupCell}, 8'h01);
        supply = 5'h00;
        step(1);
    endtask
    task automatic test_thermal();
        power_on();
        step(40);
        supply[0] = 1'b1;
        wait_restart(3);
        chk({7'h00, drive.gateEnable}, 8'h00);
        power_off();
    endtask
    task automatic test_soft_ovp();
        power_on();
        supply[4] = 1'b1;
        step(30);
        no_restart();
        supply[4] = 1'b0;
        fbMv = 13'h125c;
        step(30);
        no_restart();
        chk({6'h00, drive.pinClamp, drive.reducedLimit}, 8'h02);
        supply[4] = 1'b1;
        wait_restart(3);
        fbMv = 13'h09c4;
        power_off();
    endtask
    task automatic test_ovp_filter();
        power_on();
        supply[3] = 1'b1;
        step(2300);
        no_restart();
        // A dip must restart the 120us window
        supply[3] = 1'b0;
        step(60);
        supply[3] = 1'b1;
        step(2300);
        no_restart();
        wait_restart(200);
        power_off();
    endtask
    task automatic test_ext_request();
        power_on();
        extReq = 1'b1;
        step(18500);
        no_restart();
        wait_restart(1600);
        extReq = 1'b0;
        power_off();
    endtask
    initial
    begin
        step(5);
        rst = 1'b0;
        chk(drive, 8'h28);
        test_thermal();
        test_soft_ovp();
        test_ovp_filter();
        test_ext_request();
        final_report();
    end
endmodule
